// File: core/caf_regs.svh
// Purpose: register offsets, write masks and reset values for the filter control block
// Assumes: apb byte addresses, one aligned 32-bit word per register
// Notes: definitions only
`ifndef CAF_REGS_SVH
`define CAF_REGS_SVH
`define CAF_OFF_CTRL_8_11 12'h000
`define CAF_OFF_CTRL_12_15 12'h004
`define CAF_OFF_CTRL_16_19 12'h008
`define CAF_OFF_MASK0 12'h010
`define CAF_OFF_MASK1 12'h014
`define CAF_OFF_MASK2 12'h018
`define CAF_OFF_MASK3 12'h01C
`define CAF_OFF_MODE 12'h020
`define CAF_OFF_FILT_ID_BASE 12'h040
`define CAF_CTRL_RESET 32'h0000_0000
`define CAF_MASK_RESET 32'h0000_0000
`define CAF_MODE_RESET 3'h0
`define CAF_MODE_CONFIG 3'h4
`define CAF_MASK_WMASK 32'hFFEB_FFFF
`define CAF_ID_WMASK 32'hFFEB_FFFF
`define CAF_MODE_WIDTH 3
`define CAF_FIRST_FILTER 8
`endif

// File: core/caf_pkg.sv
// Purpose: types shared by the filter control block
// Assumes: caf_regs.svh supplies the numbers
// Notes: slot layout is enable, mask choice, destination buffer
package caf_pkg;
   typedef struct packed {
      logic filter_active_bit;
      logic [1:0] mask_choice_field;
      logic [4:0] dest_buffer_field;
   } caf_slot_s;
   typedef struct packed {
      logic [10:0] sid;
      logic [17:0] eid;
      logic ide;
   } caf_msg_s;
   typedef struct packed {
      logic hit;
      logic [4:0] buffer;
      logic [4:0] filter;
   } caf_result_s;
endpackage

// File: core/caf_match.sv
// Purpose: one filter compare against a message under its chosen mask
// Assumes: mask and identifier words in the shared mask-register layout
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none
module caf_match (
   input wire caf_pkg::caf_msg_s msg,
   input wire logic [31:0] idWord,
   input wire logic [31:0] maskWord,
   input wire logic active,
   output logic hit
);
   import caf_pkg::*;
   logic sidOk;
   logic eidOk;
   logic typeOk;
   always_comb begin
      sidOk = ((msg.sid ^ idWord[31:21]) & maskWord[31:21]) == 11'h000;
      eidOk = ((msg.eid ^ idWord[17:0]) & maskWord[17:0]) == 18'h0_0000;
      typeOk = !maskWord[19] || (msg.ide == idWord[19]);
      hit = active && typeOk && sidOk && (eidOk || !msg.ide);
   end
endmodule // caf_match
`default_nettype wire

// File: core/caf_filter_ctrl.sv
// Purpose: apb control of acceptance filters 8..19, masks and receive steering
// Assumes: apb slave, one wait state, 50 MHz clock
// Notes: receive result is registered one cycle after msgValid
`timescale 1ns/1ps
`default_nettype none
`include "caf_regs.svh"
// Contract
// - each byte: bit7 enable, bits6:5 mask choice, bits4:0 destination buffer
// - lowest filter of a register in bits 7:0, highest in 31:24
// - registers hold filters 8-11, 12-15 and 16-19 in that order
// - enabled filters take part in acceptance, disabled ones do not
// - mask choice 0..3 selects acceptance mask 0..3
// - destination field value is the receive buffer number 0..31
// - mask and buffer fields ignore writes while their filter is enabled
// - all control bits read/write and reset to zero
// - mask one bit compares, zero bit is don't-care
// - type-match bit set demands equal frame format
// - mask registers writable only in configuration mode 100
module caf_filter_ctrl #(
   parameter int NUM_FILTERS = 12
) (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic msgValid,
   input wire caf_pkg::caf_msg_s msgIn,
   output caf_pkg::caf_result_s resultOut,
   output logic resultValid
);
   import caf_pkg::*;

   // elaboration check: the slot decode assumes three full control words
   if (NUM_FILTERS != 12) begin : gBadCount
      $error("only twelve filters are supported");
   end

   logic rstMeta;
   logic rstSync;
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rstMeta <= 1'b0;
         rstSync <= 1'b0;
      end else begin
         rstMeta <= 1'b1;
         rstSync <= rstMeta;
      end
   end

   logic [31:0] ctrl_reg [3];
   logic [31:0] ctrl_next [3];
   logic [31:0] mask_reg [4];
   logic [31:0] mask_next [4];
   logic [31:0] id_reg [NUM_FILTERS];
   logic [31:0] id_next [NUM_FILTERS];
   logic [2:0] mode_reg;
   logic [2:0] mode_next;
   logic [31:0] prdata_next;
   logic pslverr_next;
   logic wrEn;
   logic rdEn;
   logic cfgMode;

   // apb access phase; answered after one wait state
   assign wrEn = psel && penable && pwrite;
   assign rdEn = psel && penable && !pwrite;
   assign cfgMode = (mode_reg == `CAF_MODE_CONFIG);

   // locked byte keeps selectors; enable bit itself always writable
   function automatic logic [31:0] ctrl_merge(input logic [31:0] cur, input logic [31:0] wd);
      logic [31:0] res;
      res = cur;
      for (int b = 0; b < 4; b++) begin
         res[8*b+7] = wd[8*b+7];
         if (!cur[8*b+7]) res[8*b +: 7] = wd[8*b +: 7];
      end
      return res;
   endfunction

   function automatic caf_slot_s slot_of(input logic [31:0] regs [3], input int f);
      return caf_slot_s'(regs[f/4][8*(f%4) +: 8]);
   endfunction

   always_comb begin
      ctrl_next = ctrl_reg;
      mask_next = mask_reg;
      id_next = id_reg;
      mode_next = mode_reg;
      if (wrEn) begin
         for (int r = 0; r < 3; r++) begin
            if (paddr == `CAF_OFF_CTRL_8_11 + 12'(4 * r)) begin
               ctrl_next[r] = ctrl_merge(ctrl_reg[r], pwdata);
            end
         end
         for (int m = 0; m < 4; m++) begin
            if (cfgMode && paddr == `CAF_OFF_MASK0 + 12'(4 * m)) begin
               mask_next[m] = pwdata & `CAF_MASK_WMASK;
            end
         end
         for (int f = 0; f < NUM_FILTERS; f++) begin
            if (cfgMode && paddr == `CAF_OFF_FILT_ID_BASE + 12'(4 * f)) begin
               id_next[f] = pwdata & `CAF_ID_WMASK;
            end
         end
         if (paddr == `CAF_OFF_MODE) mode_next = pwdata[`CAF_MODE_WIDTH-1:0];
      end
   end

   always_comb begin
      prdata_next = 32'h0000_0000;
      pslverr_next = 1'b0;
      if (rdEn) begin
         pslverr_next = 1'b1;
         for (int r = 0; r < 3; r++) begin
            if (paddr == `CAF_OFF_CTRL_8_11 + 12'(4 * r)) begin
               prdata_next = ctrl_reg[r];
               pslverr_next = 1'b0;
            end
         end
         for (int m = 0; m < 4; m++) begin
            if (paddr == `CAF_OFF_MASK0 + 12'(4 * m)) begin
               prdata_next = mask_reg[m];
               pslverr_next = 1'b0;
            end
         end
         for (int f = 0; f < NUM_FILTERS; f++) begin
            if (paddr == `CAF_OFF_FILT_ID_BASE + 12'(4 * f)) begin
               prdata_next = id_reg[f];
               pslverr_next = 1'b0;
            end
         end
         if (paddr == `CAF_OFF_MODE) begin
            prdata_next = {29'h0000_0000, mode_reg};
            pslverr_next = 1'b0;
         end
      end
   end

   // read data registered so prdata comes from a flop; answer is one cycle late
   // so slave inserts a single wait state via pready
   logic pready_next;
   assign pready_next = psel && penable && !pready;

   always_ff @(posedge clock or negedge rstSync) begin
      if (!rstSync) begin
         for (int r = 0; r < 3; r++) ctrl_reg[r] <= `CAF_CTRL_RESET;
         for (int m = 0; m < 4; m++) mask_reg[m] <= `CAF_MASK_RESET;
         for (int f = 0; f < NUM_FILTERS; f++) id_reg[f] <= `CAF_MASK_RESET;
         mode_reg <= `CAF_MODE_RESET;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
         pready <= 1'b0;
      end else begin
         if (pready) begin
            ctrl_reg <= ctrl_next;
            mask_reg <= mask_next;
            id_reg <= id_next;
            mode_reg <= mode_next;
         end
         prdata <= prdata_next;
         pslverr <= pslverr_next && pready_next;
         pready <= pready_next;
      end
   end

   // acceptance path
   logic [NUM_FILTERS-1:0] hits;
   for (genvar g = 0; g < NUM_FILTERS; g++) begin : gFilt
      caf_slot_s s;
      assign s = slot_of(ctrl_reg, g);
      caf_match uMatch (
         .msg(msgIn),
         .idWord(id_reg[g]),
         .maskWord(mask_reg[s.mask_choice_field]),
         .active(s.filter_active_bit),
         .hit(hits[g])
      );
   end

   caf_result_s result_next;
   logic resultValid_next;
   always_comb begin
      caf_slot_s sl;
      sl = '0;
      result_next = '0;
      resultValid_next = msgValid;
      for (int f = NUM_FILTERS - 1; f >= 0; f--) begin
         if (hits[f]) begin
            sl = slot_of(ctrl_reg, f);
            result_next.hit = 1'b1;
            result_next.buffer = sl.dest_buffer_field;
            result_next.filter = 5'(f + `CAF_FIRST_FILTER);
         end
      end
      if (!msgValid) result_next = '0;
   end

   always_ff @(posedge clock or negedge rstSync) begin
      if (!rstSync) begin
         resultOut <= '0;
         resultValid <= 1'b0;
      end else begin
         resultOut <= result_next;
         resultValid <= resultValid_next;
      end
   end

   lock_hold_a: assert property (@(posedge clock) disable iff (!rstSync)
      (wrEn && pready && paddr == `CAF_OFF_CTRL_8_11 && ctrl_reg[0][7])
      |=> ctrl_reg[0][6:0] == $past(ctrl_reg[0][6:0])) else $error("locked slot changed");

   unlock_write_a: assert property (@(posedge clock) disable iff (!rstSync)
      (wrEn && pready && paddr == `CAF_OFF_CTRL_12_15 && !ctrl_reg[1][15])
      |=> ctrl_reg[1][15:8] == $past(pwdata[15:8])) else $error("free slot not written");

   enable_write_a: assert property (@(posedge clock) disable iff (!rstSync)
      (wrEn && pready && paddr == `CAF_OFF_CTRL_8_11)
      |=> ctrl_reg[0][7] == $past(pwdata[7])) else $error("enable bit not written");

   lock_top_a: assert property (@(posedge clock) disable iff (!rstSync)
      (wrEn && pready && paddr == `CAF_OFF_CTRL_16_19 && ctrl_reg[2][31])
      |=> ctrl_reg[2][30:24] == $past(ctrl_reg[2][30:24])) else $error("top slot changed");

   mask_gate_a: assert property (@(posedge clock) disable iff (!rstSync)
      (!cfgMode) |=> $stable(mask_reg[2])) else $error("mask changed outside config");

   mask_write_a: assert property (@(posedge clock) disable iff (!rstSync)
      (wrEn && pready && cfgMode && paddr == `CAF_OFF_MASK1)
      |=> mask_reg[1] == ($past(pwdata) & `CAF_MASK_WMASK)) else $error("mask write lost");

   id_gate_a: assert property (@(posedge clock) disable iff (!rstSync)
      (!cfgMode) |=> $stable(id_reg[0])) else $error("identifier changed outside config");

   read_back_a: assert property (@(posedge clock) disable iff (!rstSync)
      (rdEn && !pready && paddr == `CAF_OFF_CTRL_16_19)
      ##1 (rdEn && paddr == `CAF_OFF_CTRL_16_19) |-> prdata == ctrl_reg[2])
      else $error("control readback wrong");

   ready_wait_a: assert property (@(posedge clock) disable iff (!rstSync)
      (psel && penable && !pready) |=> pready) else $error("access not answered");

   ready_pulse_a: assert property (@(posedge clock) disable iff (!rstSync)
      pready |=> !pready) else $error("ready held too long");

   err_ready_a: assert property (@(posedge clock) disable iff (!rstSync)
      pslverr |-> pready) else $error("error without ready");

   no_hit_a: assert property (@(posedge clock) disable iff (!rstSync)
      (ctrl_reg[0][7] == 1'b0) |-> !hits[0]) else $error("disabled filter hit");

   result_idle_a: assert property (@(posedge clock) disable iff (!rstSync)
      !msgValid |=> !resultValid) else $error("result without message");

   miss_result_a: assert property (@(posedge clock) disable iff (!rstSync)
      (msgValid && hits == '0) |=> !resultOut.hit) else $error("miss reported as hit");

   lowest_win_a: assert property (@(posedge clock) disable iff (!rstSync)
      (msgValid && hits[0]) |=> resultOut.filter == 5'(`CAF_FIRST_FILTER)
      && resultOut.buffer == $past(ctrl_reg[0][4:0])) else $error("priority wrong");

   result_time_a: assert property (@(posedge clock) disable iff (!rstSync)
      msgValid |=> resultValid) else $error("result not one cycle later");

   slot_ten_a: assert property (@(posedge clock) disable iff (!rstSync)
      (msgValid && hits[2] && !hits[1] && !hits[0]) |=>
      resultOut.buffer == $past(ctrl_reg[0][20:16])) else $error("filter ten slot wrong");

   top_slot_a: assert property (@(posedge clock) disable iff (!rstSync)
      (msgValid && hits == {1'b1, {(NUM_FILTERS-1){1'b0}}}) |=>
      resultOut.filter == 5'(`CAF_FIRST_FILTER + NUM_FILTERS - 1)
      && resultOut.buffer == $past(ctrl_reg[2][28:24])) else $error("top slot steering wrong");

   type_check_a: assert property (@(posedge clock) disable iff (!rstSync)
      (hits[0] && mask_reg[ctrl_reg[0][6:5]][19]) |-> msgIn.ide == id_reg[0][19])
      else $error("format mismatch accepted");
endmodule // caf_filter_ctrl
`default_nettype wire

// File: bench/caf_msg_src.sv
// Purpose: receive-path source standing in for the bus side
// Assumes: one-cycle msgValid pulse per identifier
// Notes: idle data is inverted so a stale identifier differs from the one last sent
`timescale 1ns/1ps
`default_nettype none
module caf_msg_src (
   input wire logic clock,
   output var logic msgValid,
   output var caf_pkg::caf_msg_s msgIn
);
   import caf_pkg::*;
   initial begin
      msgValid = 1'b0;
      msgIn = '0;
   end
   task automatic send(input caf_msg_s m);
      @(posedge clock);
      msgValid <= 1'b1;
      msgIn <= m;
      @(posedge clock);
      msgValid <= 1'b0;
      msgIn <= ~m;
   endtask
endmodule // caf_msg_src
`default_nettype wire

// File: bench/can_acceptance_filter_control_8_to_19_bench.sv
// Purpose: self-checking bench for the filter control block
// Assumes: one wait state apb slave, result one cycle after msgValid
// Notes: filter 8 demands extended frames, filter 19 catches what others miss
`timescale 1ns/1ps
`default_nettype none
`include "caf_regs.svh"
module can_acceptance_filter_control_8_to_19_bench;
   import caf_pkg::*;
   logic clock, reset_n, psel, penable, pwrite, pready, pslverr, msgValid, resultValid;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   caf_msg_s msgIn;
   caf_result_s resultOut;
   int checks = 0;
   int fail_count = 0;
   initial begin
      clock = 1'b0;
      reset_n = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
   end
   always #10 clock = ~clock;
   caf_filter_ctrl dut_u (.clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .msgValid(msgValid), .msgIn(msgIn), .resultOut(resultOut),
      .resultValid(resultValid));
   caf_msg_src src_u (.clock(clock), .msgValid(msgValid), .msgIn(msgIn));
   task automatic test_done();
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic chk_result(input caf_result_s exp);
      checks++;
      if (resultValid !== 1'b1 || resultOut.hit !== exp.hit ||
          (exp.hit && resultOut !== exp)) begin
         fail_count++;
         $display("[ERR] %0t result got %h exp %h", $time, resultOut, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
      int n;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         fail_count++;
         $display("[ERR] %0t apb answer missing", $time);
         test_done();
      end else begin
         q = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic expErr);
      logic [31:0] q;
      logic e;
      apb(1'b0, a, 32'h0000_0000, q, e);
      chk_word(q, exp, "read data");
      chk_word({31'h0000_0000, e}, {31'h0000_0000, expErr}, "slave error");
   endtask
   task automatic t_send(input logic [10:0] s, input logic x, input caf_result_s exp);
      src_u.send('{s, 18'h2_a5a5, x});
      @(posedge clock);
      chk_result(exp);
   endtask
   task automatic t_reset();
      for (int i = 0; i < 3; i++) begin
         rd_chk(`CAF_OFF_CTRL_8_11 + 12'(4 * i), `CAF_CTRL_RESET, 1'b0);
      end
      rd_chk(12'h0FC, 32'h0000_0000, 1'b1);
   endtask
   task automatic t_rw_lock();
      logic [11:0] a;
      for (int i = 0; i < 3; i++) begin
         a = `CAF_OFF_CTRL_8_11 + 12'(4 * i);
         wr(a, 32'h5A5A_5A5A);
         rd_chk(a, 32'h5A5A_5A5A, 1'b0);
         wr(a, 32'hFFFF_FFFF);
         wr(a, 32'h0000_0000);
         rd_chk(a, 32'h7F7F_7F7F, 1'b0);
         wr(a, 32'h0000_0000);
         rd_chk(a, 32'h0000_0000, 1'b0);
      end
   endtask
   task automatic t_mask_mode();
      wr(`CAF_OFF_MASK0, 32'hFFFF_FFFF);
      rd_chk(`CAF_OFF_MASK0, `CAF_MASK_RESET, 1'b0);
      // software enters configuration mode before touching masks
      wr(`CAF_OFF_MODE, {29'h0000_0000, `CAF_MODE_CONFIG});
      rd_chk(`CAF_OFF_MODE, {29'h0000_0000, `CAF_MODE_CONFIG}, 1'b0);
      wr(`CAF_OFF_MASK1, 32'hFFE0_0000);
      rd_chk(`CAF_OFF_MASK1, 32'hFFE0_0000, 1'b0);
      // unimplemented mask bits 20 and 18 read as zero
      wr(`CAF_OFF_MASK3, 32'hFFFF_FFFF);
      rd_chk(`CAF_OFF_MASK3, 32'hFFEB_FFFF, 1'b0);
   endtask
   task automatic t_steer();
      wr(`CAF_OFF_FILT_ID_BASE + 12'h004, 32'h2460_0000);
      wr(`CAF_OFF_FILT_ID_BASE + 12'h008, 32'h2460_0000);
      // filter 9: mask 1, buffer 31; filter 10: mask 1, buffer 3
      wr(`CAF_OFF_CTRL_8_11, 32'h00A3_BF00);
      t_send(11'h123, 1'b0, '{1'b1, 5'd31, 5'd9});
      t_send(11'h123, 1'b1, '{1'b1, 5'd31, 5'd9});
      t_send(11'h124, 1'b0, '{1'b0, 5'd0, 5'd0});
      // enable cleared first so the slot may be changed later
      wr(`CAF_OFF_CTRL_8_11, 32'h00A3_0000);
      rd_chk(`CAF_OFF_CTRL_8_11, 32'h00A3_3F00, 1'b0);
      t_send(11'h123, 1'b0, '{1'b1, 5'd3, 5'd10});
   endtask
   task automatic t_type();
      // filter 8: mask 2 wants extended frames, buffer 5; filter 19: mask 0, buffer 17
      wr(`CAF_OFF_MASK2, 32'hFFE8_0000);
      rd_chk(`CAF_OFF_MASK2, 32'hFFE8_0000, 1'b0);
      wr(`CAF_OFF_FILT_ID_BASE, 32'h2468_0000);
      wr(`CAF_OFF_CTRL_8_11, 32'h00A3_3FC5);
      wr(`CAF_OFF_CTRL_16_19, 32'h9100_0000);
      t_send(11'h123, 1'b0, '{1'b1, 5'd3, 5'd10});
      t_send(11'h123, 1'b1, '{1'b1, 5'd5, 5'd8});
      t_send(11'h124, 1'b0, '{1'b1, 5'd17, 5'd19});
   endtask
   initial begin
      repeat (8) @(posedge clock);
      reset_n <= 1'b1;
      repeat (3) @(posedge clock);
      t_reset();
      t_rw_lock();
      t_mask_mode();
      t_steer();
      t_type();
      test_done();
   end
endmodule // can_acceptance_filter_control_8_to_19_bench
`default_nettype wire
